// file: inc/i2m_pkg.sv
// constants, states and helpers shared by both ends of the i2c to mdio bridge
package i2m_pkg;
   // i2c slave address and the two address bytes
   localparam logic [6:0] I2M_SLAVE_ADDR = 7'h56;
   localparam logic [7:0] I2M_ADDR_WR = 8'hAC;
   localparam logic [7:0] I2M_ADDR_RD = 8'hAD;
   // frame lengths in bytes, address byte included except in the read data count; spoilt-frame count
   localparam logic [2:0] I2M_WR_BYTES = 3'h6;
   localparam logic [2:0] I2M_RDREQ_BYTES = 3'h4;
   localparam logic [2:0] I2M_RD_BYTES = 3'h2;
   localparam logic [2:0] I2M_BAD_CNT = 3'h7;
   // device-select byte: read flag position
   localparam int I2M_SEL_RD_BIT = 5;
   // timing: system clock and the i2c clock the host makes
   localparam int I2M_CLK_PERIOD_NS = 10;
   localparam int I2M_LINK_PERIOD_NS = 200;
   localparam int I2M_QTR_CYC = I2M_LINK_PERIOD_NS / 4 / I2M_CLK_PERIOD_NS;
   // management clock period and its half in clock cycles
   localparam int I2M_MDC_PERIOD_NS = 400;
   localparam int I2M_MDC_HALF_CYC = I2M_MDC_PERIOD_NS / 2 / I2M_CLK_PERIOD_NS;
   // indirect management frame fields
   localparam logic [1:0] I2M_MD_ST = 2'h0;
   localparam logic [1:0] I2M_MD_OP_ADDR = 2'h0;
   localparam logic [1:0] I2M_MD_OP_WR = 2'h1;
   localparam logic [1:0] I2M_MD_OP_RD = 2'h3;
   localparam logic [1:0] I2M_MD_TA = 2'h2;
   localparam logic [5:0] I2M_MD_LAST = 6'h3F;
   localparam logic [5:0] I2M_MD_RD_REL = 6'h2E;
   localparam logic [5:0] I2M_MD_RD_DATA = 6'h30;
   // bridge i2c states, gray along idle-recv-ack-send-rack
   typedef enum logic [2:0] {
      I2M_D_IDLE = 3'b000, I2M_D_RECV = 3'b001, I2M_D_ACK = 3'b011,
      I2M_D_SEND = 3'b010, I2M_D_RACK = 3'b110
   } i2m_dst_t;
   // management engine states
   typedef enum logic [1:0] {
      I2M_M_IDLE = 2'b00, I2M_M_ADDR = 2'b01, I2M_M_DATA = 2'b11
   } i2m_mst_t;
   // host states
   typedef enum logic [1:0] {
      I2M_H_IDLE = 2'b00, I2M_H_START = 2'b01, I2M_H_BIT = 2'b11, I2M_H_STOP = 2'b10
   } i2m_hst_t;
   // build one 64-bit management frame, preamble included
   function automatic logic [63:0] i2m_md_frame(input logic [1:0] op, input logic [4:0] prt,
                                                input logic [4:0] dev, input logic [15:0] val);
      i2m_md_frame = {32'hFFFFFFFF, I2M_MD_ST, op, prt, dev, I2M_MD_TA, val};
   endfunction : i2m_md_frame
endpackage : i2m_pkg

// file: inc/i2m_if.sv
// two-wire link between host and bridge, open drain with pull-ups
`timescale 1ns/1ps
`default_nettype none
interface i2m_if;
   logic scl_h_o; // host clock drive value
   logic scl_h_oe; // host drives clock
   logic sda_h_o; // host data drive value
   logic sda_h_oe; // host drives data
   logic scl_d_o; // bridge clock drive value (stretch)
   logic scl_d_oe; // bridge drives clock
   logic sda_d_o; // bridge data drive value
   logic sda_d_oe; // bridge drives data
   logic scl; // resolved clock wire
   logic sda; // resolved data wire
   // wired-and with pull-up: released means high
   assign scl = (scl_h_oe ? scl_h_o : 1'b1) & (scl_d_oe ? scl_d_o : 1'b1);
   assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
   modport host (output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, input scl, sda);
   modport dev (output scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, input scl, sda);
endinterface : i2m_if
`default_nettype wire

// file: rtl/i2m_host.sv
// host end: i2c master issuing bridge write and read transfers
`timescale 1ns/1ps
`default_nettype none
module i2m_host
   import i2m_pkg::*;
#(
   parameter int QTR_CYC = I2M_QTR_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   i2m_if.host bus,
   input wire logic go,
   input wire logic rw,
   input wire logic [4:0] devad,
   input wire logic [15:0] regaddr,
   input wire logic [15:0] wdata,
   output logic busy,
   output logic done,
   output logic nack,
   output logic [15:0] rdata
);
   ////////////////////////////////////////////////////////////////////////
   i2m_hst_t state; // transfer state
   logic [7:0] qcnt; // quarter-bit counter
   logic [1:0] q; // quarter within a bit
   logic seg; // 0 request frame, 1 read-back frame
   logic [2:0] bi; // byte index in frame
   logic [3:0] bitn; // bit index, 8 is ack slot
   logic [7:0] rxsr; // received byte
   logic r_rw; // latched request
   logic [4:0] r_dev;
   logic [15:0] r_ra;
   logic [15:0] r_wd;
   logic [2:0] scl_sy; // three-stage synchronisers
   logic [2:0] sda_sy;
   logic scl_f; // filtered wire levels
   logic sda_f;
   logic tick; // quarter ends
   logic wait_hi; // quarter stalled until clock seen high
   logic last_b; // current byte is the last of frame
   logic rx_b; // current byte is read from bridge
   logic [7:0] txb; // current byte to send

   // byte to send for a given frame and index
   function automatic logic [7:0] host_byte(input logic s, input logic [2:0] i);
      logic [7:0] b;
      b = I2M_ADDR_RD; // read-back frame opens with read address [RULE8]
      if (!s) begin
         case (i)
            3'h0: b = I2M_ADDR_WR; // [RULE1]
            3'h1: b = {2'b00, r_rw, r_dev}; // read flag in bit 5 [RULE3] [RULE7]
            3'h2: b = r_ra[15:8]; // [RULE4]
            3'h3: b = r_ra[7:0];
            3'h4: b = r_wd[15:8]; // [RULE5]
            default: b = r_wd[7:0];
         endcase
      end
      host_byte = b;
   endfunction : host_byte

   assign txb = host_byte(seg, bi);
   assign rx_b = seg && (bi != 3'h0);
   // request is 4 or 6 bytes, read-back is address plus two [RULE2] [RULE6]
   assign last_b = seg ? (bi == I2M_RD_BYTES) : (bi == (r_rw ? I2M_RDREQ_BYTES : I2M_WR_BYTES) - 3'h1);
   // quarter two follows the release; it waits until the wire is seen high
   assign wait_hi = (state != I2M_H_IDLE) && (q == 2'h2) && !scl_f;
   assign tick = (qcnt == 8'(QTR_CYC - 1)) && !wait_hi;
   assign busy = (state != I2M_H_IDLE);
   assign bus.scl_h_o = 1'b0;
   assign bus.sda_h_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // synchronise the wires; a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
      end else if (ce) begin
         scl_sy <= {scl_sy[1:0], bus.scl};
         sda_sy <= {sda_sy[1:0], bus.sda};
         if (scl_sy[1] == scl_sy[2]) scl_f <= scl_sy[2];
         if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
      end
   end

   // quarter timer; stalls while the bridge stretches the clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qcnt <= 8'h00;
      end else if (ce) begin
         if (state == I2M_H_IDLE || tick) qcnt <= 8'h00;
         else if (!wait_hi) qcnt <= qcnt + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame sequencer: start, bytes, stop, optional read-back frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= I2M_H_IDLE;
         q <= 2'h0;
         seg <= 1'b0;
         bi <= 3'h0;
         bitn <= 4'h0;
         rxsr <= 8'h00;
         bus.scl_h_oe <= 1'b0;
         bus.sda_h_oe <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         rdata <= 16'h0000;
         r_rw <= 1'b0;
         r_dev <= 5'h00;
         r_ra <= 16'h0000;
         r_wd <= 16'h0000;
      end else if (ce) begin
         done <= 1'b0;
         case (state)
            I2M_H_IDLE: begin
               if (go) begin
                  r_rw <= rw;
                  r_dev <= devad;
                  r_ra <= regaddr;
                  r_wd <= wdata;
                  nack <= 1'b0;
                  seg <= 1'b0;
                  q <= 2'h0;
                  state <= I2M_H_START;
               end
            end
            I2M_H_START: if (tick) begin
               q <= q + 2'h1;
               case (q)
                  2'h0: bus.scl_h_oe <= 1'b0; // both released, bus idle
                  2'h1: bus.sda_h_oe <= 1'b1; // data falls with clock high
                  2'h2: bus.scl_h_oe <= 1'b1;
                  default: begin
                     bi <= 3'h0;
                     bitn <= 4'h0;
                     state <= I2M_H_BIT;
                  end
               endcase
            end
            I2M_H_BIT: if (tick) begin
               q <= q + 2'h1;
               case (q)
                  2'h0: begin
                     // set data while clock low
                     if (bitn[3]) bus.sda_h_oe <= rx_b && !last_b;
                     else bus.sda_h_oe <= !rx_b && !txb[3'h7 - bitn[2:0]];
                  end
                  2'h1: bus.scl_h_oe <= 1'b0;
                  2'h2: begin
                     if (!bitn[3]) rxsr <= {rxsr[6:0], sda_f};
                     else if (!rx_b && sda_f) nack <= 1'b1;
                     else if (rx_b && bi == 3'h1) rdata[15:8] <= rxsr; // msb first
                     else if (rx_b) rdata[7:0] <= rxsr;
                  end
                  default: begin
                     bus.scl_h_oe <= 1'b1;
                     bitn <= bitn + 4'h1;
                     if (bitn[3]) begin
                        bitn <= 4'h0;
                        bi <= bi + 3'h1;
                        if (nack || last_b) state <= I2M_H_STOP;
                     end
                  end
               endcase
            end
            I2M_H_STOP: if (tick) begin
               q <= q + 2'h1;
               case (q)
                  2'h0: bus.sda_h_oe <= 1'b1;
                  2'h1: bus.scl_h_oe <= 1'b0;
                  2'h2: bus.sda_h_oe <= 1'b0; // data rises with clock high
                  default: begin
                     if (!seg && r_rw && !nack) begin
                        seg <= 1'b1; // second frame collects the value [RULE8]
                        state <= I2M_H_START;
                     end else begin
                        done <= 1'b1;
                        state <= I2M_H_IDLE;
                     end
                  end
               endcase
            end
            default: state <= I2M_H_IDLE;
         endcase
      end
   end
endmodule : i2m_host
`default_nettype wire

// file: rtl/i2m_bridge.sv
// bridge end: i2c slave that turns frames into indirect management accesses
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] answer slave address 0x56, bytes 0xAC/0xAD
// [RULE2] register write is one six-byte frame
// [RULE3] select byte: device in 4:0, bit5 clear writes
// [RULE4] register address two bytes, high first
// [RULE5] two data bytes high first, then written
// [RULE6] read request is a four-byte write frame
// [RULE7] select bit5 set, bits 7:6 zero reads
// [RULE8] host opens second frame with read address
// [RULE9] read frame returns exactly two bytes, msb first
// [RULE10] each accepted request becomes a management access; one arriving while the engine is busy is dropped
// [RULE11] address cycle first, then write or read
// [RULE12] hold clock low until read data ready
module i2m_bridge
   import i2m_pkg::*;
#(
   parameter logic [4:0] PHY_PRTAD = 5'h00,
   parameter int MDC_HALF = I2M_MDC_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   i2m_if.dev bus,
   output logic mdc,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic mdio_i
);
   ////////////////////////////////////////////////////////////////////////
   logic [2:0] scl_sy, sda_sy, mdi_sy; // three-stage synchronisers
   logic scl_f, sda_f, mdi_f; // filtered levels
   logic scl_rise, scl_fall; // wire events, one cycle each
   logic i2c_start, i2c_stop; // start and stop conditions seen
   i2m_dst_t state; // i2c slave state
   logic [3:0] bitn; // bits seen in current byte
   logic [2:0] bcnt; // acked bytes in frame, 7 marks a spoilt frame
   logic [7:0] sr, txsr; // receive and transmit shifters
   logic rd_mode, mack; // frame addressed for read, master acked last byte
   logic loaded, sent; // first read byte on the wire, second under way
   logic [7:0] devsel; // device-select byte
   logic [15:0] regaddr, wdata; // assembled register address and write data
   logic rd_pend; // read requested, value not yet back
   logic kick_wr, kick_rd; // frame end events
   i2m_mst_t mstate; // management engine state
   logic [7:0] mdiv; // clock divider
   logic [5:0] mcnt; // bit index in frame
   logic [63:0] msr; // frame shifter
   logic m_wr; // engine carries a write
   logic [15:0] mrd, rdval; // read shifter and last value read
   logic m_tick, m_fall, m_rise; // divider events
   // select byte: bits 7:6 must be clear for both kinds
   function automatic logic sel_ok(input logic [7:0] b);
      sel_ok = (b[7:6] == 2'b00);
   endfunction : sel_ok

   ////////////////////////////////////////////////////////////////////////
   // synchronise pins; a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
         mdi_sy <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         mdi_f <= 1'b1;
      end else if (ce) begin
         scl_sy <= {scl_sy[1:0], bus.scl};
         sda_sy <= {sda_sy[1:0], bus.sda};
         mdi_sy <= {mdi_sy[1:0], mdio_i};
         if (scl_sy[1] == scl_sy[2]) scl_f <= scl_sy[2];
         if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
         if (mdi_sy[1] == mdi_sy[2]) mdi_f <= mdi_sy[2];
      end
   end

   // edge and condition detection on the filtered levels
   assign scl_rise = (scl_sy[1] == scl_sy[2]) && scl_sy[2] && !scl_f;
   assign scl_fall = (scl_sy[1] == scl_sy[2]) && !scl_sy[2] && scl_f;
   assign i2c_start = (sda_sy[1] == sda_sy[2]) && !sda_sy[2] && sda_f && scl_f;
   assign i2c_stop = (sda_sy[1] == sda_sy[2]) && sda_sy[2] && !sda_f && scl_f;
   // open-drain drives: ack, read data bits, clock stretch
   assign bus.scl_d_o = 1'b0;
   assign bus.sda_d_o = 1'b0;
   assign bus.sda_d_oe = (state == I2M_D_ACK) || ((state == I2M_D_SEND) && loaded && !txsr[7]);
   // stretch only in the clock-low phase after the read address ack [RULE12]
   assign bus.scl_d_oe = (state == I2M_D_SEND) && !loaded;

   ////////////////////////////////////////////////////////////////////////
   // i2c slave byte machine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= I2M_D_IDLE;
         bitn <= 4'h0;
         bcnt <= I2M_BAD_CNT;
         sr <= 8'h00;
         txsr <= 8'hFF;
         rd_mode <= 1'b0;
         loaded <= 1'b0;
         sent <= 1'b0;
         mack <= 1'b0;
         devsel <= 8'h00;
         regaddr <= 16'h0000;
         wdata <= 16'h0000;
      end else if (ce) begin
         if (i2c_start) begin
            // repeated start also ends the previous frame
            state <= I2M_D_RECV;
            bitn <= 4'h0;
            bcnt <= 3'h0;
            rd_mode <= 1'b0;
         end else if (i2c_stop) begin
            state <= I2M_D_IDLE;
            bcnt <= I2M_BAD_CNT; // no second kick from a stray stop
         end else begin
            case (state)
               I2M_D_RECV: begin
                  if (scl_rise) begin
                     sr <= {sr[6:0], sda_f};
                     bitn <= bitn + 4'h1;
                  end else if (scl_fall && bitn[3]) begin
                     bitn <= 4'h0;
                     state <= I2M_D_ACK;
                     bcnt <= bcnt + 3'h1;
                     case (bcnt)
                        3'h0: begin
                           rd_mode <= sr[0];
                           if (sr[7:1] != I2M_SLAVE_ADDR) state <= I2M_D_IDLE; // [RULE1]
                        end
                        3'h1: begin
                           devsel <= sr; // [RULE3] [RULE7]
                           if (!sel_ok(sr) || rd_mode) state <= I2M_D_IDLE;
                        end
                        3'h2: regaddr[15:8] <= sr; // [RULE4]
                        3'h3: regaddr[7:0] <= sr;
                        3'h4: begin
                           wdata[15:8] <= sr; // [RULE5]
                           // a read request stops at four bytes [RULE6]
                           if (devsel[I2M_SEL_RD_BIT]) state <= I2M_D_IDLE;
                        end
                        3'h5: wdata[7:0] <= sr;
                        default: state <= I2M_D_IDLE; // over six bytes [RULE2]
                     endcase
                     // refused byte: no ack, frame spoilt
                     if ((bcnt == 3'h0 && sr[7:1] != I2M_SLAVE_ADDR) || (bcnt == 3'h1 && !sel_ok(sr))
                         || (bcnt == 3'h4 && devsel[I2M_SEL_RD_BIT]) || bcnt >= I2M_WR_BYTES
                         || (bcnt != 3'h0 && rd_mode)) begin
                        bcnt <= I2M_BAD_CNT;
                     end
                  end
               end
               I2M_D_ACK: if (scl_fall) begin
                  loaded <= 1'b0;
                  sent <= 1'b0;
                  state <= rd_mode ? I2M_D_SEND : I2M_D_RECV;
               end
               I2M_D_SEND: begin
                  // wait here with the clock held until the value is back [RULE12]
                  if (!loaded && !rd_pend) begin
                     txsr <= rdval[15:8]; // msb first [RULE9]
                     loaded <= 1'b1;
                  end else if (loaded && scl_fall) begin
                     txsr <= {txsr[6:0], 1'b1};
                     bitn <= bitn + 4'h1;
                     if (bitn == 4'h7) begin
                        bitn <= 4'h0;
                        state <= I2M_D_RACK;
                     end
                  end
               end
               I2M_D_RACK: begin
                  if (scl_rise) mack <= !sda_f;
                  else if (scl_fall) begin
                     if (mack && !sent) begin
                        sent <= 1'b1;
                        txsr <= rdval[7:0];
                        state <= I2M_D_SEND;
                     end else begin
                        state <= I2M_D_IDLE; // never more than two bytes [RULE9]
                     end
                  end
               end
               default: state <= I2M_D_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame end: decide whether a complete request was received
   assign kick_wr = (i2c_start || i2c_stop) && !rd_mode && bcnt == I2M_WR_BYTES
                    && !devsel[I2M_SEL_RD_BIT]; // [RULE2] [RULE3]
   assign kick_rd = (i2c_start || i2c_stop) && !rd_mode && bcnt == I2M_RDREQ_BYTES
                    && devsel[I2M_SEL_RD_BIT]; // [RULE6] [RULE7]
   // read pending flag; the done event wins over nothing, a new kick sets it only while the engine is idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend <= 1'b0;
      end else if (ce) begin
         if (kick_rd && mstate == I2M_M_IDLE) rd_pend <= 1'b1;
         else if (mstate == I2M_M_DATA && m_fall && mcnt == I2M_MD_LAST) rd_pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // management clock divider, runs only during a frame
   assign m_tick = (mdiv == 8'(MDC_HALF - 1));
   assign m_fall = m_tick && mdc;
   assign m_rise = m_tick && !mdc;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mdiv <= 8'h00;
         mdc <= 1'b0;
      end else if (ce) begin
         // counter and clock both rest low while the engine is idle
         mdiv <= (mstate == I2M_M_IDLE || m_tick) ? 8'h00 : mdiv + 8'h01;
         mdc <= (mstate != I2M_M_IDLE) && (mdc ^ m_tick);
      end
   end
   // indirect access engine: address frame, then write or read frame
   // requests arriving while busy are dropped; the host waits for the read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mstate <= I2M_M_IDLE;
         mcnt <= 6'h00;
         msr <= 64'hFFFFFFFFFFFFFFFF;
         m_wr <= 1'b0;
         mrd <= 16'h0000;
         rdval <= 16'h0000;
      end else if (ce) begin
         case (mstate)
            I2M_M_IDLE: if (kick_wr || kick_rd) begin
               // [RULE10] [RULE11]
               msr <= i2m_md_frame(I2M_MD_OP_ADDR, PHY_PRTAD, devsel[4:0], regaddr);
               m_wr <= kick_wr;
               mcnt <= 6'h00;
               mstate <= I2M_M_ADDR;
            end
            I2M_M_ADDR: begin
               if (m_fall) begin
                  msr <= {msr[62:0], 1'b1};
                  mcnt <= mcnt + 6'h01;
                  if (mcnt == I2M_MD_LAST) begin
                     // same device, now the data cycle [RULE11] [RULE5]
                     msr <= i2m_md_frame(m_wr ? I2M_MD_OP_WR : I2M_MD_OP_RD, PHY_PRTAD,
                                         devsel[4:0], wdata);
                     mcnt <= 6'h00;
                     mstate <= I2M_M_DATA;
                  end
               end
            end
            I2M_M_DATA: begin
               if (m_rise && !m_wr && mcnt >= I2M_MD_RD_DATA) mrd <= {mrd[14:0], mdi_f};
               if (m_fall) begin
                  msr <= {msr[62:0], 1'b1};
                  mcnt <= mcnt + 6'h01;
                  if (mcnt == I2M_MD_LAST) begin
                     if (!m_wr) rdval <= mrd;
                     mstate <= I2M_M_IDLE;
                  end
               end
            end
            default: mstate <= I2M_M_IDLE;
         endcase
      end
   end

   // management pin drive; released for turnaround and data of a read
   assign mdio_o = msr[63];
   assign mdio_oe = (mstate == I2M_M_ADDR) || (mstate == I2M_M_DATA && (m_wr || mcnt < I2M_MD_RD_REL));
endmodule : i2m_bridge
`default_nettype wire

// file: tb/i2m_monitor.sv
// link, handshake and management pin checks for the joined host and bridge
`timescale 1ns/1ps
`default_nettype none
module i2m_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic scl_d_o,
   input wire logic scl_d_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe,
   input wire logic go,
   input wire logic busy,
   input wire logic done,
   input wire logic mdc,
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // frame kick: ones with mdc low, then preamble ones held while driving
   sequence s_pre; (mdio_o && !mdc) ##1 (mdio_o && mdio_oe)[*8]; endsequence
   property p_od; (scl_d_oe || sda_d_oe) |-> !(scl_d_o || sda_d_o); endproperty
   a_od: assert property (p_od) else $error("bridge drives a high level");
   // data may only move while the clock wire was low
   property p_sda_chg; $changed(sda_d_oe) |-> !$past(scl); endproperty
   a_sda_chg: assert property (p_sda_chg) else $error("bridge data moved with clock high");
   property p_str_rise; $rose(scl_d_oe) |-> !$past(scl); endproperty
   a_str_rise: assert property (p_str_rise) else $error("stretch began with clock high");
   property p_mdc_half; $changed(mdc) |=> $stable(mdc)[*8]; endproperty
   a_mdc_half: assert property (p_mdc_half) else $error("management clock half too short");
   property p_pre; $rose(mdio_oe) |-> s_pre; endproperty
   a_pre: assert property (p_pre) else $error("management frame without preamble");
   property p_done_idle; done |-> !busy; endproperty
   a_done_idle: assert property (p_done_idle) else $error("done while busy");
   property p_go_busy; (go && !busy) |=> busy; endproperty
   a_go_busy: assert property (p_go_busy) else $error("request not taken");
   property p_done_pulse; done |=> !done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
endmodule : i2m_monitor
`default_nettype wire

// file: tb/tb_top.sv
// bench: host and bridge joined on one link, phy side answered by a shift model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import i2m_pkg::*;
   logic clk = 0, rst_n = 0, ce = 0, go = 0, rw = 0, busy, done, nack, mdc, mdio_o, mdio_oe, mdio_i = 1, mdc_q = 0;
   logic [4:0] devad = 0;
   logic [15:0] regaddr = 0, wdata = 0, rdata;
   logic [127:0] cap = 0; // last two management frames, taken on mdc rise
   logic [17:0] sh = 0; // released and zero turnaround bits, then read value, shifted to the bridge
   int miscompares = 0, check_count = 0;
   i2m_if bus ();
   i2m_host i_i2m_host (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus.host), .go(go), .rw(rw), .devad(devad),
      .regaddr(regaddr), .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
   i2m_bridge i_i2m_bridge (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus.dev), .mdc(mdc), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .mdio_i(mdio_i));
   i2m_monitor i_i2m_monitor (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .scl_d_o(bus.scl_d_o),
      .scl_d_oe(bus.scl_d_oe), .sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe), .go(go), .busy(busy),
      .done(done), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe));
   initial begin
      forever #5 clk = ~clk;
   end
   // capture on mdc rise; answer on mdc fall only once the bridge lets go
   always @(posedge clk) begin
      mdc_q <= mdc;
      if (mdc && !mdc_q) begin
         cap <= {cap[126:0], mdio_o};
      end
      if (!mdc && mdc_q && !mdio_oe) begin
         mdio_i <= sh[17];
         sh <= {sh[16:0], 1'b1}; // released line drifts to its pull-up
      end
   end
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // one transfer; wd is the write value or the value the phy returns
   task automatic xfer(input logic r, input logic [4:0] d, input logic [15:0] ra, input logic [15:0] wd);
      int n;
      logic [127:0] exp;
      exp = {32'hFFFFFFFF, 4'h0, 5'h00, d, 2'h2, ra, 32'hFFFFFFFF, 2'h0, r ? 2'h3 : 2'h1, 5'h00, d, 2'h2, wd};
      @(posedge clk);
      go <= 1;
      rw <= r;
      devad <= d;
      regaddr <= ra;
      wdata <= wd;
      sh <= {2'b10, wd}; // msb lands on the fall that opens bit 48
      @(posedge clk);
      go <= 0;
      n = 0;
      while (done !== 1'b1 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      if (n == 40000) begin
         miscompares++;
         give_verdict();
      end
      chk(nack, 0);
      repeat (5300) @(posedge clk); // 128 mdc periods of 40 clk each
      chk(r ? cap >> 18 : cap, r ? exp >> 18 : exp);
   endtask : xfer
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      ce <= 1;
      xfer(0, 5'h1F, 16'h8001, 16'hA55A);
      xfer(1, 5'h01, 16'hFFFF, 16'h5AC3);
      chk(rdata, 16'h5AC3);
      xfer(1, 5'h00, 16'h0000, 16'h8001);
      chk(rdata, 16'h8001);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
